// file: asrc_host.sv
// Host controller driving an asynchronous byte-wide static RAM.
// Assumes user requests on clk; the SRAM data bus comes back through pins.
// Function
// - Read: select and gate low, strobe high
// - Address valid before select falls; here both change on the same clock edge
// - Data timed from ending strobe edge
// - Address setup/hold, select 10 ns early
// - Data setup 9 ns, strobe 9 ns, cycle 15
// - Strobe-low release 7 ns before drive; here drive starts on the same clock edge as strobe falls
// - Host never drives while device drives
// - Retention: deselect first, wait 200 us
`timescale 1ns/10ps
module asrc_host #(
  parameter int ADDR_W = 15,
  parameter int RECOVERY_CYCLES = asrc_pkg::RECOVERY_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // User request side
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic req_ready_ff,
  output logic rsp_valid_ff,
  output logic [7:0] rsp_rdata_ff,
  // Data retention control
  input wire logic retain_req,
  output logic retain_ok_ff,
  // SRAM pins
  output logic [ADDR_W-1:0] sram_addr_ff,
  output logic sram_sel_n_ff,
  output logic sram_wr_n_ff,
  output logic sram_gate_n_ff,
  input wire logic [7:0] sram_data_in,
  output logic [7:0] sram_data_out_ff,
  output logic sram_data_oe_ff
);
  // Elaboration checks: the counter must hold every wait, or it would wrap short
  if (ADDR_W < 1 || ADDR_W > 32) begin : g_bad_addr_w
    $error("asrc_host: ADDR_W out of range");
  end
  if (RECOVERY_CYCLES < 1 ||
    RECOVERY_CYCLES >= (1 << asrc_pkg::CNT_W) * 2) begin : g_bad_recovery
    $error("asrc_host: RECOVERY_CYCLES out of range");
  end
  if (asrc_pkg::READ_WAIT_CYC >= (1 << asrc_pkg::CNT_W) ||
    asrc_pkg::STROBE_CYC >= (1 << asrc_pkg::CNT_W) ||
    asrc_pkg::READ_CYCLE_CYC >= (1 << asrc_pkg::CNT_W) ||
    asrc_pkg::WRITE_CYCLE_CYC >= (1 << asrc_pkg::CNT_W)) begin : g_bad_counts
    $error("asrc_host: package wait counts overflow the counter");
  end

  asrc_pkg::asrc_state_t state_ff, nxt_state;
  logic [asrc_pkg::CNT_W:0] cnt_ff;
  logic [asrc_pkg::CNT_W:0] nxt_cnt;
  logic [7:0] din_s1_ff, din_s2_ff;
  logic ret_s1_ff, ret_s2_ff;
  logic rd_pend_ff;
  logic [7:0] rd_cap_ff;
  logic [1:0] rd_pipe_ff;

  // Pin controls decode the next state so every pin leaves a flop
  function automatic logic sel_state(input asrc_pkg::asrc_state_t s);
    return s == asrc_pkg::ASRC_RD || s == asrc_pkg::ASRC_WR || s == asrc_pkg::ASRC_WREND;
  endfunction : sel_state

  function automatic logic drive_state(input asrc_pkg::asrc_state_t s);
    return s == asrc_pkg::ASRC_WR || s == asrc_pkg::ASRC_WREND;
  endfunction : drive_state

  // Pins pass two flops before the FSM looks at them
  always_ff @(posedge clk) begin
    din_s1_ff <= sram_data_in;
    din_s2_ff <= din_s1_ff;
    ret_s1_ff <= retain_req;
    ret_s2_ff <= ret_s1_ff;
  end

  function automatic logic [asrc_pkg::CNT_W:0] cnt_of(input int c);
    return c[asrc_pkg::CNT_W:0];
  endfunction : cnt_of

  always_comb begin
    nxt_state = state_ff;
    // Counter stops at zero; RD, WR, GAP and RECOV test it for their own exit
    nxt_cnt = (cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;
    case (state_ff)
      asrc_pkg::ASRC_IDLE: begin
        if (ret_s2_ff) begin
          nxt_state = asrc_pkg::ASRC_RECOV;
          nxt_cnt = cnt_of(RECOVERY_CYCLES);
        end else if (req_valid && req_ready_ff) begin
          nxt_state = req_write ? asrc_pkg::ASRC_WR : asrc_pkg::ASRC_RD;
          nxt_cnt = req_write ? cnt_of(asrc_pkg::STROBE_CYC) : cnt_of(asrc_pkg::READ_WAIT_CYC);
        end
      end
      asrc_pkg::ASRC_RD: begin
        if (cnt_ff == cnt_of(1)) begin
          nxt_state = asrc_pkg::ASRC_GAP;
          nxt_cnt = cnt_of(asrc_pkg::READ_CYCLE_CYC);
        end
      end
      asrc_pkg::ASRC_WR: begin
        if (cnt_ff == cnt_of(1)) begin
          nxt_state = asrc_pkg::ASRC_WREND;
        end
      end
      asrc_pkg::ASRC_WREND: begin
        // Strobe already high; select and data stay one more cycle for hold
        nxt_state = asrc_pkg::ASRC_GAP;
        nxt_cnt = cnt_of(asrc_pkg::WRITE_CYCLE_CYC);
      end
      asrc_pkg::ASRC_GAP: begin
        // Deselected gap keeps successive accesses apart
        if (cnt_ff <= cnt_of(1)) nxt_state = asrc_pkg::ASRC_IDLE;
      end
      asrc_pkg::ASRC_RECOV: begin
        // recovery wait after supply return
        // Reload while retention is asked, so the full wait follows its end
        if (!ret_s2_ff && cnt_ff == '0) nxt_state = asrc_pkg::ASRC_IDLE;
        if (ret_s2_ff) nxt_cnt = cnt_of(RECOVERY_CYCLES);
      end
      default: begin
        // Illegal codes fall back to idle with select high
        nxt_state = asrc_pkg::ASRC_IDLE;
        nxt_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= asrc_pkg::ASRC_IDLE;
      cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // Address and write data latched once per request
  // Only a taken request moves the address, so it never moves while selected
  always_ff @(posedge clk) begin
    if (rst) begin
      sram_addr_ff <= '0;
      sram_data_out_ff <= 8'h00;
    end else if (state_ff == asrc_pkg::ASRC_IDLE && req_valid && req_ready_ff && !ret_s2_ff) begin
      sram_addr_ff <= req_addr;
      sram_data_out_ff <= req_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sram_sel_n_ff <= 1'b1;
      sram_wr_n_ff <= 1'b1;
      sram_gate_n_ff <= 1'b1;
      sram_data_oe_ff <= 1'b0;
    end else begin
      sram_sel_n_ff <= !sel_state(nxt_state);
      // strobe rises first to end the write
      sram_wr_n_ff <= !(nxt_state == asrc_pkg::ASRC_WR);
      sram_gate_n_ff <= !(nxt_state == asrc_pkg::ASRC_RD);
      // drive only while gate is high
      // data held past the ending edge
      sram_data_oe_ff <= drive_state(nxt_state);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      req_ready_ff <= 1'b0;
      rsp_valid_ff <= 1'b0;
      rsp_rdata_ff <= 8'h00;
      retain_ok_ff <= 1'b0;
    end else begin
      // Ready also watches the first sync stage, so no request is taken
      // on the edge at which a retention request turns the FSM away
      req_ready_ff <= (nxt_state == asrc_pkg::ASRC_IDLE) && !ret_s1_ff && !ret_s2_ff;
      retain_ok_ff <= (nxt_state == asrc_pkg::ASRC_RECOV) && ret_s2_ff;
      // Answer once the captured byte has left the synchroniser; the FSM may
      // already be on the next access, which does not disturb the capture
      rsp_valid_ff <= rd_pend_ff;
      if (rd_pend_ff) rsp_rdata_ff <= rd_cap_ff;
    end
  end

  // Capture read byte at access end; it reaches the sync stage two cycles on
  // Pin data is steady only near the access end, so a tag pipeline picks it out
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_pipe_ff <= 2'b00;
      rd_pend_ff <= 1'b0;
      rd_cap_ff <= 8'h00;
    end else begin
      rd_pipe_ff <= {rd_pipe_ff[0], (state_ff == asrc_pkg::ASRC_RD) && (cnt_ff == cnt_of(1))};
      if (rd_pipe_ff[1]) rd_cap_ff <= din_s2_ff;
      rd_pend_ff <= rd_pipe_ff[1];
    end
  end
endmodule : asrc_host

// file: asrc_pkg.sv
// Timing and encoding constants for the async SRAM host controller.
// Assumes a single 10 MHz system clock; all counts are in clk cycles.
package asrc_pkg;
  localparam int CLK_PERIOD_NS = 100;
  // Device timing figures, in their own units
  localparam int READ_CYCLE_MIN_NS = 15;
  localparam int ADDR_ACCESS_DELAY_NS = 15;
  localparam int SELECT_ACCESS_DELAY_NS = 15;
  localparam int GATE_ACCESS_DELAY_NS = 7;
  localparam int WRITE_CYCLE_MIN_NS = 15;
  localparam int SELECT_TO_WRITE_END_NS = 10;
  localparam int ADDR_SETUP_WRITE_END_NS = 10;
  localparam int STROBE_PULSE_MIN_NS = 9;
  localparam int WDATA_SETUP_NS = 9;
  localparam int STROBE_LOW_RELEASE_NS = 7;
  localparam int RETENTION_RECOVERY_US = 200;
  // Least times round up, never below one cycle
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_up
  localparam int READ_WAIT_CYC = cyc_up(SELECT_ACCESS_DELAY_NS > ADDR_ACCESS_DELAY_NS ?
    SELECT_ACCESS_DELAY_NS : ADDR_ACCESS_DELAY_NS);
  localparam int READ_CYCLE_CYC = cyc_up(READ_CYCLE_MIN_NS);
  localparam int STROBE_CYC = cyc_up(STROBE_PULSE_MIN_NS > WDATA_SETUP_NS ?
    STROBE_PULSE_MIN_NS : WDATA_SETUP_NS);
  localparam int WRITE_CYCLE_CYC = cyc_up(WRITE_CYCLE_MIN_NS);
  localparam int RECOVERY_CYC = cyc_up(RETENTION_RECOVERY_US * 1000);
  localparam int CNT_W = 12;
  typedef enum logic [5:0] {
    ASRC_IDLE  = 6'h01,
    ASRC_RD    = 6'h02,
    ASRC_WR    = 6'h04,
    ASRC_WREND = 6'h08,
    ASRC_GAP   = 6'h10,
    ASRC_RECOV = 6'h20
  } asrc_state_t;
endpackage : asrc_pkg

// file: asrc_sram_model.sv
// Behavioural byte-wide static RAM on the host controller's pins.
// Assumes zero pin delays; a released bus shows the inverse of the last byte.
`timescale 1ns/10ps
module asrc_sram_model (
  // Pins
  input wire logic [14:0] addr,
  input wire logic sel_n,
  input wire logic wr_n,
  input wire logic gate_n,
  input wire logic [7:0] din,
  output logic [7:0] dout
);
  logic [7:0] mem [0:32767];
  logic [7:0] last_ff = 8'h00;
  logic rd;
  logic wr_on;
  assign wr_on = !sel_n && !wr_n;
  always @(negedge wr_on) mem[addr] = din;
  assign rd = !sel_n && !gate_n && wr_n;
  always @* if (rd) last_ff = mem[addr];
  assign dout = rd ? mem[addr] : ~last_ff;
endmodule : asrc_sram_model

// file: asrc_host_asserts.sv
// Pin protocol checks for asrc_host, bound to its ports.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/10ps
module asrc_host_chk #(
  parameter int ADDR_W = 15,
  parameter int RECOVERY_CYCLES = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // User side
  input wire logic rsp_valid_ff,
  input wire logic retain_ok_ff,
  // Pins
  input wire logic [ADDR_W-1:0] sram_addr_ff,
  input wire logic sram_sel_n_ff,
  input wire logic sram_wr_n_ff,
  input wire logic sram_gate_n_ff,
  input wire logic [7:0] sram_data_out_ff,
  input wire logic sram_data_oe_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Cycles left before select may fall again after retention
  int rec_cnt_ff;
  always_ff @(posedge clk) begin
    if (rst) rec_cnt_ff <= 0;
    else if (retain_ok_ff) rec_cnt_ff <= RECOVERY_CYCLES - 1;
    else if (rec_cnt_ff != 0) rec_cnt_ff <= rec_cnt_ff - 1;
  end
  property p_rd_ctl; !sram_gate_n_ff |-> sram_wr_n_ff && !sram_sel_n_ff; endproperty
  a_rd_ctl: assert property (p_rd_ctl) else $error("gate low outside read");
  property p_addr; !$past(sram_sel_n_ff) && !sram_sel_n_ff |-> $stable(sram_addr_ff); endproperty
  a_addr: assert property (p_addr) else $error("address moved while selected");
  property p_sel_end; $rose(sram_wr_n_ff) |-> !$past(sram_sel_n_ff); endproperty
  a_sel_end: assert property (p_sel_end) else $error("select late for write");
  property p_wdata; !$past(sram_wr_n_ff) |-> $stable(sram_data_out_ff) && sram_data_oe_ff;
  endproperty
  a_wdata: assert property (p_wdata) else $error("write data not held");
  property p_clash; sram_data_oe_ff |-> sram_gate_n_ff; endproperty
  a_clash: assert property (p_clash) else $error("host drives during read");
  property p_rsp; !sram_gate_n_ff ##1 sram_gate_n_ff |-> ##[1:12] rsp_valid_ff; endproperty
  a_rsp: assert property (p_rsp) else $error("read answer missing");
  property p_gap; $rose(sram_sel_n_ff) |=> sram_sel_n_ff; endproperty
  a_gap: assert property (p_gap) else $error("cycles too close");
  property p_ret; retain_ok_ff |-> sram_sel_n_ff && !sram_data_oe_ff; endproperty
  a_ret: assert property (p_ret) else $error("selected in retention");
  property p_recov; rec_cnt_ff != 0 |-> sram_sel_n_ff; endproperty
  a_recov: assert property (p_recov) else $error("recovery cut short");
endmodule : asrc_host_chk
bind asrc_host asrc_host_chk #(.ADDR_W(ADDR_W), .RECOVERY_CYCLES(RECOVERY_CYCLES)) chk_i (.*);

// file: asrc_host_test.sv
// Self-checking bench for asrc_host driving the behavioural RAM.
// Assumes the RAM model answers with zero delay.
`timescale 1ns/10ps
module asrc_host_test;
  logic clk, rst, req_valid, req_write, req_ready_ff, rsp_valid_ff, retain_req, retain_ok_ff;
  logic sram_sel_n_ff, sram_wr_n_ff, sram_gate_n_ff, sram_data_oe_ff;
  logic [14:0] req_addr, sram_addr_ff;
  logic [7:0] req_wdata, rsp_rdata_ff, sram_data_out_ff, sram_data_in, dev_q;
  logic [14:0] at [4] = '{15'h0000, 15'h7FFF, 15'h2AAA, 15'h5555};
  logic [7:0] dt [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h00};
  int mismatches = 0;
  int total_checks = 0;
  localparam int REC_CYC = 4;
  asrc_host #(.RECOVERY_CYCLES(REC_CYC)) asrc_host_i (.clk(clk), .rst(rst),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready_ff(req_ready_ff), .rsp_valid_ff(rsp_valid_ff), .rsp_rdata_ff(rsp_rdata_ff),
    .retain_req(retain_req), .retain_ok_ff(retain_ok_ff), .sram_addr_ff(sram_addr_ff),
    .sram_sel_n_ff(sram_sel_n_ff), .sram_wr_n_ff(sram_wr_n_ff), .sram_gate_n_ff(sram_gate_n_ff),
    .sram_data_in(sram_data_in), .sram_data_out_ff(sram_data_out_ff),
    .sram_data_oe_ff(sram_data_oe_ff));
  asrc_sram_model asrc_sram_model_i (.addr(sram_addr_ff), .sel_n(sram_sel_n_ff),
    .wr_n(sram_wr_n_ff), .gate_n(sram_gate_n_ff), .din(sram_data_in), .dout(dev_q));
  // Host drive wins only while its enable is up
  assign sram_data_in = sram_data_oe_ff ? sram_data_out_ff : dev_q;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  task automatic xfer(input logic w, input logic [14:0] a, input logic [7:0] d,
    output logic [7:0] q);
    logic r;
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    do begin
      @(negedge clk);
      r = req_ready_ff;
      @(posedge clk);
      n++;
    end while (r !== 1'b1 && n < 99);
    req_valid <= 1'b0;
    if (r !== 1'b1) mismatches++;
    n = 0;
    while (!w && n < 40) begin
      @(negedge clk);
      n = (rsp_valid_ff === 1'b1) ? 99 : n + 1;
    end
    if (n == 40) mismatches++;
    q = rsp_rdata_ff;
    @(posedge clk);
  endtask : xfer
  task automatic t_fill;
    logic [7:0] q;
    for (int i = 0; i < 4; i++) xfer(1'b1, at[i], dt[i], q);
    for (int i = 3; i >= 0; i--) begin
      xfer(1'b0, at[i], 8'h00, q);
      chk(q, dt[i]);
    end
  endtask : t_fill
  task automatic t_overwrite;
    logic [7:0] q;
    xfer(1'b1, at[1], 8'h3C, q);
    xfer(1'b1, at[1], 8'hC3, q);
    xfer(1'b0, at[1], 8'h00, q);
    chk(q, 8'hC3);
    xfer(1'b0, at[0], 8'h00, q);
    chk(q, 8'hA5);
  endtask : t_overwrite
  task automatic t_retain;
    logic [7:0] q;
    int k;
    retain_req <= 1'b1;
    for (int n = 0; n < 40 && retain_ok_ff !== 1'b1; n++) @(negedge clk);
    chk({7'h00, retain_ok_ff}, 8'h01);
    chk({7'h00, sram_sel_n_ff}, 8'h01);
    @(posedge clk);
    retain_req <= 1'b0;
    // No access may start before the recovery wait has run out
    for (k = 0; k < 40 && req_ready_ff !== 1'b1; k++) @(negedge clk);
    chk({7'h00, k >= REC_CYC}, 8'h01);
    @(posedge clk);
    xfer(1'b0, at[2], 8'h00, q);
    chk(q, 8'hFF);
  endtask : t_retain
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 15'h0000;
    req_wdata = 8'h00;
    retain_req = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_fill;
    t_overwrite;
    t_retain;
    test_done;
  end
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    test_done;
  end
endmodule : asrc_host_test
